//--- logic/status_out_pkg.sv
// Package of constants and types for the servo status-output block
`default_nettype none
package status_out_pkg;

  // ****************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] LOW_SPEED_OFS   = 8'h04;
  localparam logic [7:0] ARRIVE_SPD_OFS  = 8'h08;
  localparam logic [7:0] POS_WINDOW_OFS  = 8'h0C;
  localparam logic [7:0] BRAKE_DLY_OFS   = 8'h10;
  localparam logic [7:0] FLAGS_OFS       = 8'h14;
  localparam logic [7:0] INT_STATUS_OFS  = 8'h18;
  localparam logic [7:0] INT_MASK_OFS    = 8'h1C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_BRAKE_MODE_BIT = 0;
  localparam int EVT_FAULT_BIT       = 0;
  localparam int EVT_LOW_SPEED_BIT   = 1;
  localparam int EVT_TORQUE_BIT      = 2;
  localparam int EVT_ARRIVAL_BIT     = 3;
  localparam int EVT_BRAKE_BIT       = 4;
  localparam int EVT_W               = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        CTRL_RST       = 1'b0;
  localparam logic [15:0] LOW_SPEED_RST  = 16'h0000;
  localparam logic [15:0] ARRIVE_SPD_RST = 16'h0000;
  localparam logic [23:0] POS_WINDOW_RST = 24'h000000;
  localparam logic [15:0] BRAKE_DLY_RST  = 16'h0000;
  localparam logic [4:0]  INT_MASK_RST   = 5'h00;

  // ****************************************************************
  // Timing: brake delay counts in milliseconds
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 50;
  localparam int DELAY_UNIT_NS  = 1000000;
  localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_POSITION,
    MODE_SPEED,
    MODE_TORQUE,
    MODE_SPARE
  } op_mode_t;

  typedef enum logic {
    BRAKE_SERVO_READY,
    BRAKE_RELEASE
  } brake_mode_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } enc_phase_t;

  typedef struct packed {
    logic a;
    logic a_n;
    logic b;
    logic b_n;
    logic c;
    logic c_n;
  } enc_diff_t;

  typedef struct packed {
    logic        alarm;
    logic        servo_on;
    op_mode_t    mode;
    logic [15:0] speed_mag;
    logic [15:0] torque_mag;
    logic [15:0] torque_limit;
    logic [23:0] pos_err_mag;
  } drive_state_t;

endpackage : status_out_pkg
`default_nettype wire

//--- logic/servo_status_outputs.sv
// Status-output logic of the servo drive with its register port
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`default_nettype none
module servo_status_outputs #(
  parameter int DELAY_UNIT_CYC = status_out_pkg::DELAY_UNIT_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         ce,
  input  wire logic [7:0]                   addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [31:0]                  rdata,
  output logic                              irq,
  input  wire status_out_pkg::drive_state_t drive,
  input  wire status_out_pkg::enc_phase_t   enc_in,
  output logic                              fault_flag_out,
  output logic                              brake_out,
  output logic                              low_speed_out,
  output logic                              torque_saturated_flag,
  output logic                              arrival_flag,
  output status_out_pkg::enc_diff_t         enc_out
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  status_out_pkg::brake_mode_t brake_mode_reg;
  status_out_pkg::brake_mode_t brake_mode_next;
  logic [15:0]                 low_speed_reg;
  logic [15:0]                 low_speed_next;
  logic [15:0]                 arrive_spd_reg;
  logic [15:0]                 arrive_spd_next;
  logic [23:0]                 pos_window_reg;
  logic [23:0]                 pos_window_next;
  logic [15:0]                 brake_dly_reg;
  logic [15:0]                 brake_dly_next;
  logic [4:0]                  int_mask_reg;
  logic [4:0]                  int_mask_next;
  logic [4:0]                  int_status_reg;
  logic [4:0]                  int_status_next;
  logic [31:0]                 rdata_reg;
  logic [31:0]                 rdata_next;
  logic                        irq_reg;
  logic                        irq_next;

  // ****************************************************************
  // Status flag state
  // ****************************************************************
  logic [4:0]                  flags_reg;
  logic [4:0]                  flags_next;
  status_out_pkg::enc_diff_t   enc_reg;
  status_out_pkg::enc_diff_t   enc_next;

  // ****************************************************************
  // Brake sequencer state
  // ****************************************************************
  typedef enum logic [1:0] {
    BR_HELD,
    BR_WAIT,
    BR_RELEASED
  } brake_state_t;

  brake_state_t                brake_state_reg;
  brake_state_t                brake_state_next;
  logic [31:0]                 unit_cnt_reg;
  logic [31:0]                 unit_cnt_next;
  logic [15:0]                 dly_cnt_reg;
  logic [15:0]                 dly_cnt_next;

  logic [4:0]                  flags_now;
  logic [4:0]                  events;
  logic                        brake_now;

  // ****************************************************************
  // Flag comparisons
  // ****************************************************************
  always_comb
  begin
    flags_now = '0;
    flags_now[status_out_pkg::EVT_FAULT_BIT] = drive.alarm;
    flags_now[status_out_pkg::EVT_LOW_SPEED_BIT] =
      drive.speed_mag < low_speed_reg;
    // Saturation counts only while the torque loop is in charge
    flags_now[status_out_pkg::EVT_TORQUE_BIT] =
      (drive.mode == status_out_pkg::MODE_TORQUE)
      && (drive.torque_mag >= drive.torque_limit);
    unique case (drive.mode)
      status_out_pkg::MODE_POSITION:
        flags_now[status_out_pkg::EVT_ARRIVAL_BIT] =
          drive.pos_err_mag < pos_window_reg;
      status_out_pkg::MODE_SPEED:
        flags_now[status_out_pkg::EVT_ARRIVAL_BIT] =
          drive.speed_mag < arrive_spd_reg;
      status_out_pkg::MODE_TORQUE,
      status_out_pkg::MODE_SPARE:
        flags_now[status_out_pkg::EVT_ARRIVAL_BIT] = 1'b0;
    endcase
    flags_now[status_out_pkg::EVT_BRAKE_BIT] = brake_now;
  end

  // ****************************************************************
  // Brake sequencer
  // ****************************************************************
  always_comb
  begin
    brake_state_next = brake_state_reg;
    unit_cnt_next    = unit_cnt_reg;
    dly_cnt_next     = dly_cnt_reg;
    brake_now        = 1'b0;
    if (brake_mode_reg == status_out_pkg::BRAKE_SERVO_READY)
    begin
      // No delay in this mode; sequencer parks so a later switch starts clean
      brake_state_next = BR_HELD;
      brake_now        = drive.servo_on && !drive.alarm;
    end
    else
    begin
      unique case (brake_state_reg)
        BR_HELD:
        begin
          unit_cnt_next = '0;
          dly_cnt_next  = '0;
          if (drive.servo_on)
          begin
            if (brake_dly_reg == 16'h0000)
            begin
              brake_state_next = BR_RELEASED;
              brake_now        = 1'b1;
            end
            else
            begin
              brake_state_next = BR_WAIT;
            end
          end
        end
        BR_WAIT:
        begin
          if (!drive.servo_on)
          begin
            brake_state_next = BR_HELD;
          end
          else if (unit_cnt_reg == 32'(DELAY_UNIT_CYC - 1))
          begin
            unit_cnt_next = '0;
            dly_cnt_next  = dly_cnt_reg + 16'h0001;
            if (dly_cnt_reg + 16'h0001 >= brake_dly_reg)
            begin
              brake_state_next = BR_RELEASED;
              brake_now        = 1'b1;
            end
          end
          else
          begin
            unit_cnt_next = unit_cnt_reg + 32'h0000_0001;
          end
        end
        BR_RELEASED:
        begin
          brake_now = drive.servo_on;
          if (!drive.servo_on)
          begin
            brake_state_next = BR_HELD;
          end
        end
        default:
        begin
          brake_state_next = BR_HELD;
        end
      endcase
    end
  end

  // ****************************************************************
  // Flags, encoder drivers, events
  // ****************************************************************
  always_comb
  begin
    flags_next = flags_now;
    events     = flags_now & ~flags_reg;
    // Feedback phases pass straight through, so forward order is preserved
    enc_next.a   = enc_in.a;
    enc_next.a_n = ~enc_in.a;
    enc_next.b   = enc_in.b;
    enc_next.b_n = ~enc_in.b;
    enc_next.c   = enc_in.c;
    enc_next.c_n = ~enc_in.c;
  end

  // ****************************************************************
  // Register port and interrupt
  // ****************************************************************
  always_comb
  begin
    brake_mode_next = brake_mode_reg;
    low_speed_next  = low_speed_reg;
    arrive_spd_next = arrive_spd_reg;
    pos_window_next = pos_window_reg;
    brake_dly_next  = brake_dly_reg;
    int_mask_next   = int_mask_reg;
    int_status_next = int_status_reg;
    rdata_next      = '0;
    if (wr)
    begin
      unique case (addr)
        status_out_pkg::CTRL_OFS:
          brake_mode_next = status_out_pkg::brake_mode_t'(
            wdata[status_out_pkg::CTRL_BRAKE_MODE_BIT]);
        status_out_pkg::LOW_SPEED_OFS:  low_speed_next  = wdata[15:0];
        status_out_pkg::ARRIVE_SPD_OFS: arrive_spd_next = wdata[15:0];
        status_out_pkg::POS_WINDOW_OFS: pos_window_next = wdata[23:0];
        status_out_pkg::BRAKE_DLY_OFS:  brake_dly_next  = wdata[15:0];
        status_out_pkg::INT_STATUS_OFS: int_status_next = int_status_reg & ~wdata[4:0];
        status_out_pkg::INT_MASK_OFS:   int_mask_next   = wdata[4:0];
        default:                        ;
      endcase
    end
    // New events win over a clear in the same cycle
    int_status_next = int_status_next | events;
    if (rd)
    begin
      unique case (addr)
        status_out_pkg::CTRL_OFS:       rdata_next = {31'h0, brake_mode_reg};
        status_out_pkg::LOW_SPEED_OFS:  rdata_next = {16'h0000, low_speed_reg};
        status_out_pkg::ARRIVE_SPD_OFS: rdata_next = {16'h0000, arrive_spd_reg};
        status_out_pkg::POS_WINDOW_OFS: rdata_next = {8'h00, pos_window_reg};
        status_out_pkg::BRAKE_DLY_OFS:  rdata_next = {16'h0000, brake_dly_reg};
        status_out_pkg::FLAGS_OFS:      rdata_next = {27'h0, flags_reg};
        status_out_pkg::INT_STATUS_OFS: rdata_next = {27'h0, int_status_reg};
        status_out_pkg::INT_MASK_OFS:   rdata_next = {27'h0, int_mask_reg};
        default:                        rdata_next = '0;
      endcase
    end
    irq_next = |(int_status_next & int_mask_next);
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      brake_mode_reg  <= status_out_pkg::brake_mode_t'(status_out_pkg::CTRL_RST);
      low_speed_reg   <= status_out_pkg::LOW_SPEED_RST;
      arrive_spd_reg  <= status_out_pkg::ARRIVE_SPD_RST;
      pos_window_reg  <= status_out_pkg::POS_WINDOW_RST;
      brake_dly_reg   <= status_out_pkg::BRAKE_DLY_RST;
      int_mask_reg    <= status_out_pkg::INT_MASK_RST;
      int_status_reg  <= '0;
      rdata_reg       <= '0;
      irq_reg         <= 1'b0;
      flags_reg       <= '0;
      enc_reg         <= '0;
      brake_state_reg <= BR_HELD;
      unit_cnt_reg    <= '0;
      dly_cnt_reg     <= '0;
    end
    else if (ce)
    begin
      brake_mode_reg  <= brake_mode_next;
      low_speed_reg   <= low_speed_next;
      arrive_spd_reg  <= arrive_spd_next;
      pos_window_reg  <= pos_window_next;
      brake_dly_reg   <= brake_dly_next;
      int_mask_reg    <= int_mask_next;
      int_status_reg  <= int_status_next;
      rdata_reg       <= rdata_next;
      irq_reg         <= irq_next;
      flags_reg       <= flags_next;
      enc_reg         <= enc_next;
      brake_state_reg <= brake_state_next;
      unit_cnt_reg    <= unit_cnt_next;
      dly_cnt_reg     <= dly_cnt_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  assign rdata                 = rdata_reg;
  assign irq                   = irq_reg;
  assign fault_flag_out        = flags_reg[status_out_pkg::EVT_FAULT_BIT];
  assign low_speed_out         = flags_reg[status_out_pkg::EVT_LOW_SPEED_BIT];
  assign torque_saturated_flag = flags_reg[status_out_pkg::EVT_TORQUE_BIT];
  assign arrival_flag          = flags_reg[status_out_pkg::EVT_ARRIVAL_BIT];
  assign brake_out             = flags_reg[status_out_pkg::EVT_BRAKE_BIT];
  assign enc_out               = enc_reg;

endmodule : servo_status_outputs
`default_nettype wire

//--- verif/status_checks_properties.sv
// Port-level assertions for the servo status-output block
`default_nettype none
module status_checks (
  input wire logic                         clk,
  input wire logic                         reset_n,
  input wire logic                         ce,
  input wire logic [7:0]                   addr,
  input wire logic [31:0]                  wdata,
  input wire logic                         wr,
  input wire logic                         rd,
  input wire logic [31:0]                  rdata,
  input wire status_out_pkg::drive_state_t drive,
  input wire status_out_pkg::enc_phase_t   enc_in,
  input wire logic                         fault_flag_out,
  input wire logic                         brake_out,
  input wire logic                         torque_saturated_flag,
  input wire logic                         arrival_flag,
  input wire status_out_pkg::enc_diff_t    enc_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic live_reg;
  logic rel_reg;

  // Live means the previous edge was out of reset and enabled, so outputs were updated
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      live_reg <= 1'b0;
      rel_reg  <= 1'b0;
    end
    else
    begin
      live_reg <= ce;
      if (ce && wr && addr == status_out_pkg::CTRL_OFS)
        rel_reg <= wdata[0];
    end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence alarm_two;
    ce && drive.alarm ##1 ce && drive.alarm;
  endsequence

  chk_fault_follow: assert property (
    live_reg |-> fault_flag_out == $past(drive.alarm)) else $error("fault out lags alarm");
  chk_fault_hold: assert property (
    alarm_two |-> fault_flag_out ##1 fault_flag_out) else $error("fault out not held");
  chk_torque_sat: assert property (
    live_reg |-> torque_saturated_flag == ($past(drive.mode) == status_out_pkg::MODE_TORQUE
      && $past(drive.torque_mag) >= $past(drive.torque_limit))) else $error("torque flag");
  chk_arrival_off: assert property (
    live_reg && $past(drive.mode[1]) |-> !arrival_flag) else $error("arrival in torque");
  chk_enc_true: assert property (
    live_reg |-> enc_out.a == $past(enc_in.a) && enc_out.b == $past(enc_in.b)
      && enc_out.c == $past(enc_in.c)) else $error("encoder phase wrong");
  chk_enc_pairs: assert property (
    (enc_out.a ^ enc_out.a_n) && (enc_out.b ^ enc_out.b_n) && (enc_out.c ^ enc_out.c_n)
      || !live_reg) else $error("encoder pair not complementary");
  chk_brake_ready: assert property (
    live_reg && !$past(rel_reg) |-> brake_out == $past(drive.servo_on && !drive.alarm))
    else $error("servo ready wrong");
  chk_brake_drop: assert property (
    live_reg && $past(rel_reg) && !$past(drive.servo_on) |-> !brake_out)
    else $error("brake held without servo on");
  chk_rdata_idle: assert property (
    live_reg && !$past(rd) |-> rdata == 32'h00000000) else $error("read data not idle");
endmodule : status_checks
`default_nettype wire

//--- verif/host_monitor.sv
// Host-side model that latches every discrete status line it sees high
`default_nettype none
module host_monitor (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clr,
  input  wire logic [4:0] lines,
  output logic      [4:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // A host polls slowly, so short pulses are kept sticky until cleared
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      seen <= 5'h00;
    else if (clr)
      seen <= 5'h00;
    else
      seen <= seen | lines;
endmodule : host_monitor
`default_nettype wire

//--- verif/servo_status_outputs_test.sv
// Self-checking bench for the servo status-output block
`default_nettype none
module servo_status_outputs_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UNIT = 4;
  logic                         clk     = 1'b0;
  logic                         reset_n = 1'b0;
  logic                         ce      = 1'b1;
  logic                         wr      = 1'b0;
  logic                         rd      = 1'b0;
  logic [7:0]                   addr    = 8'h00;
  logic [31:0]                  wdata   = 32'h00000000;
  logic [31:0]                  rdata;
  logic                         irq;
  logic [4:0]                   seen;
  logic                         fault_flag_out, brake_out, low_speed_out;
  logic                         torque_saturated_flag, arrival_flag;
  status_out_pkg::drive_state_t drive   = '0;
  status_out_pkg::drive_state_t want    = '0;
  status_out_pkg::enc_phase_t   enc_in  = '0;
  status_out_pkg::enc_diff_t    enc_out;
  int                           n_mismatch = 0;
  int                           n_compared = 0;

  always #25 clk = ~clk;

  servo_status_outputs #(.DELAY_UNIT_CYC(UNIT)) i_servo_status_outputs (
    .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .drive(drive), .enc_in(enc_in),
    .fault_flag_out(fault_flag_out), .brake_out(brake_out), .low_speed_out(low_speed_out),
    .torque_saturated_flag(torque_saturated_flag), .arrival_flag(arrival_flag),
    .enc_out(enc_out));
  host_monitor i_host_monitor (.clk(clk), .reset_n(reset_n), .clr(1'b0), .seen(seen),
    .lines({brake_out, arrival_flag, torque_saturated_flag, low_speed_out, fault_flag_out}));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd_chk

  // Outputs are registered, so the second falling edge sees the new value
  task automatic push;
    @(posedge clk);
    drive <= want;
    repeat (2) @(negedge clk);
  endtask : push

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset_map;
    for (int i = 0; i <= 8; i++)
      rd_chk(8'(i * 4), 32'h00000000);
  endtask : test_reset_map

  task automatic test_levels;
    wr_reg(status_out_pkg::LOW_SPEED_OFS, 32'h00000064);
    wr_reg(status_out_pkg::POS_WINDOW_OFS, 32'h00000010);
    wr_reg(status_out_pkg::ARRIVE_SPD_OFS, 32'h00000032);
    want.speed_mag = 16'h0063;
    want.pos_err_mag = 24'h00000F;
    push();
    chk(low_speed_out, 1'b1);
    chk(arrival_flag, 1'b1);
    rd_chk(status_out_pkg::FLAGS_OFS, 32'h0000000A);
    want.speed_mag = 16'h0064;
    want.pos_err_mag = 24'h000010;
    push();
    chk(low_speed_out, 1'b0);
    chk(arrival_flag, 1'b0);
    want.mode = status_out_pkg::MODE_SPEED;
    want.speed_mag = 16'h0031;
    push();
    chk(arrival_flag, 1'b1);
    want.speed_mag = 16'h0032;
    push();
    chk(arrival_flag, 1'b0);
  endtask : test_levels

  task automatic test_torque;
    want.mode = status_out_pkg::MODE_TORQUE;
    want.torque_limit = 16'h00C8;
    want.torque_mag = 16'h00C7;
    want.speed_mag = 16'h0031;
    push();
    chk(torque_saturated_flag, 1'b0);
    chk(arrival_flag, 1'b0);
    want.torque_mag = 16'h00C8;
    push();
    chk(torque_saturated_flag, 1'b1);
    want.mode = status_out_pkg::MODE_SPEED;
    push();
    chk(torque_saturated_flag, 1'b0);
  endtask : test_torque

  task automatic test_fault_irq;
    wr_reg(status_out_pkg::INT_MASK_OFS, 32'h00000001);
    wr_reg(status_out_pkg::INT_STATUS_OFS, 32'h0000001F);
    want.alarm = 1'b1;
    push();
    chk(fault_flag_out, 1'b1);
    chk(irq, 1'b1);
    @(negedge clk);
    chk(irq, 1'b1);
    rd_chk(status_out_pkg::FLAGS_OFS, 32'h0000000B);
    want.alarm = 1'b0;
    push();
    chk(irq, 1'b1);
    wr_reg(status_out_pkg::INT_STATUS_OFS, 32'h00000001);
    @(negedge clk);
    chk(irq, 1'b0);
    @(negedge clk);
    chk(irq, 1'b0);
    wr_reg(status_out_pkg::INT_MASK_OFS, 32'h00000000);
    want.alarm = 1'b1;
    push();
    @(negedge clk);
    chk(irq, 1'b0);
    rd_chk(status_out_pkg::INT_STATUS_OFS, 32'h00000001);
    want.alarm = 1'b0;
    push();
  endtask : test_fault_irq

  task automatic test_encoder;
    logic [2:0] p;
    for (int i = 0; i < 4; i++)
    begin
      p = 3'(12'h332 >> (9 - 3 * i));
      @(posedge clk);
      enc_in <= p;
      repeat (2) @(negedge clk);
      chk(enc_out, {p[2], ~p[2], p[1], ~p[1], p[0], ~p[0]});
    end
  endtask : test_encoder

  // Clock enable low must hold the fault output while the alarm input moves
  task automatic test_freeze;
    want.alarm = 1'b1;
    @(posedge clk);
    ce    <= 1'b0;
    drive <= want;
    repeat (3) @(negedge clk);
    chk(fault_flag_out, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(negedge clk);
    chk(fault_flag_out, 1'b1);
    want.alarm = 1'b0;
    push();
  endtask : test_freeze

  task automatic test_brake;
    int n;
    want.servo_on = 1'b1;
    push();
    chk(brake_out, 1'b1);
    want.alarm = 1'b1;
    push();
    chk(brake_out, 1'b0);
    want = '0;
    push();
    wr_reg(status_out_pkg::BRAKE_DLY_OFS, 32'h00000003);
    wr_reg(status_out_pkg::CTRL_OFS, 32'h00000001);
    want.servo_on = 1'b1;
    push();
    repeat (6) @(negedge clk);
    chk(brake_out, 1'b0);
    for (n = 8; n < 40 && brake_out !== 1'b1; n++)
      @(negedge clk);
    if (n == 40)
    begin
      chk(brake_out, 1'b1);
      finish_test();
    end
    else
    begin
      // Release lands D units after servo_on rises, one cycle of pipeline added
      chk(n == 3 * UNIT + 2, 1'b1);
      want.servo_on = 1'b0;
      push();
      chk(brake_out, 1'b0);
      chk(seen, 5'h1F);
    end
  endtask : test_brake

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    test_reset_map();
    test_levels();
    test_torque();
    test_fault_irq();
    test_encoder();
    test_freeze();
    test_brake();
    finish_test();
  end
endmodule : servo_status_outputs_test

bind servo_status_outputs status_checks i_status_checks (
  .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .drive(drive), .enc_in(enc_in), .fault_flag_out(fault_flag_out),
  .brake_out(brake_out), .torque_saturated_flag(torque_saturated_flag),
  .arrival_flag(arrival_flag), .enc_out(enc_out));
`default_nettype wire
